// ---- hdl/port_six_pkg.sv ----
// Constants for the six-bit bidirectional port with shared analog pins.
// Assumes one 200 MHz clock and a byte-wide register port of four words.
package port_six_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PIN_W = 6;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned CHAN_W = 5;
    localparam int unsigned FIELD_W = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices on the register port
    localparam logic [ADDR_W-1:0] PIN_LEVEL_DATA_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] OUTPUT_LATCH_OFS = 4'h1;
    localparam logic [ADDR_W-1:0] PIN_DIRECTION_OFS = 4'h2;
    localparam logic [ADDR_W-1:0] CONVERTER_PIN_CONFIG_OFS = 4'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions in the converter pin configuration register
    localparam int unsigned ANALOG_SELECT_LSB = 0;
    localparam int unsigned POS_REFERENCE_SELECT_BIT = 4;
    localparam int unsigned NEG_REFERENCE_SELECT_BIT = 5;
    localparam logic [DATA_W-1:0] CONFIG_WRITE_MASK = 8'h3F;

    // Pin positions with a special role
    localparam int unsigned TIMER_PIN_BIT = 4;
    localparam int unsigned CMP_REF_PIN_BIT = 2;
    localparam int unsigned NEG_REF_PIN_BIT = 2;
    localparam int unsigned POS_REF_PIN_BIT = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [PIN_W-1:0] OUTPUT_LATCH_RST = 6'h00;
    localparam logic [PIN_W-1:0] PIN_DIRECTION_RST = 6'h3F;
    localparam logic [DATA_W-1:0] CONVERTER_PIN_CONFIG_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Analog select field: codes up to ALL_ANALOG_MAX enable all five
    // channels, each code above drops the highest channel left.
    localparam logic [FIELD_W-1:0] ALL_ANALOG_MAX = 4'hA;
    localparam logic [FIELD_W-1:0] ALL_DIGITAL = 4'hF;

    // Converter channel k sits on this pin; pin 4 has no channel
    localparam int unsigned CHAN_PIN [CHAN_W] = '{0, 1, 2, 3, 5};

    ////////////////////////////////////////////////////////////////////////////
    // Input filter depth: a change counts when stages two and three agree
    localparam int unsigned SYNC_STAGES = 3;

endpackage : port_six_pkg

// ---- hdl/pin_sample_if.sv ----
// Carries raw pin levels into the sampler and filtered levels back out.
// Assumes both ends run on the block clock.
`timescale 1ns/1ps
interface pin_sample_if;
    logic [port_six_pkg::PIN_W-1:0] raw;
    logic [port_six_pkg::PIN_W-1:0] level;

    modport sampler (
        input raw,
        output level
    );

    modport user (
        output raw,
        input level
    );
endinterface : pin_sample_if

// ---- hdl/pin_sampler.sv ----
// Three-stage input sampler for the port pins.
// Assumes the raw levels come straight from asynchronous pads.
`timescale 1ns/1ps
module pin_sampler (
    input wire logic clk,
    input wire logic reset_n,
    pin_sample_if.sampler pins
);

    logic [port_six_pkg::PIN_W-1:0] stage1_reg;
    logic [port_six_pkg::PIN_W-1:0] stage2_reg;
    logic [port_six_pkg::PIN_W-1:0] stage3_reg;
    logic [port_six_pkg::PIN_W-1:0] level_reg;
    logic [port_six_pkg::PIN_W-1:0] level_next;
    logic [port_six_pkg::PIN_W-1:0] agree;

    // Stage one is read only by stage two, so a metastable value never fans out
    assign agree = ~(stage2_reg ^ stage3_reg);
    assign level_next = (agree & stage3_reg) | (~agree & level_reg);
    assign pins.level = level_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
            level_reg <= '0;
        end else begin
            stage1_reg <= pins.raw;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            level_reg <= level_next;
        end
    end

endmodule : pin_sampler

// ---- hdl/port_six_gpio.sv ----
// Six-bit bidirectional port with converter-shared pins and a timer clock pin.
// Assumes a byte register port driven on the block clock, pads outside that
// resolve pin_out and pin_oe, and a converter that reads the channel enables.
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
module port_six_gpio (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [5:0] pin_in,
    output logic [5:0] pin_out,
    output logic [5:0] pin_oe,
    input wire logic cmp_ref_out_en,
    input wire logic timer_clk_sel,
    output logic timer_ext_clock_in,
    output logic [4:0] converter_chan_en,
    output logic neg_reference_pin,
    output logic pos_reference_pin
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Number of converter channels left analog for a select code
    function automatic logic [2:0] analog_count(
        input logic [port_six_pkg::FIELD_W-1:0] code
    );
        logic [port_six_pkg::FIELD_W-1:0] drop;
        drop = 4'h0;
        if (code <= port_six_pkg::ALL_ANALOG_MAX) begin
            analog_count = 3'h5;
        end else if (code == port_six_pkg::ALL_DIGITAL) begin
            analog_count = 3'h0;
        end else begin
            drop = code - port_six_pkg::ALL_ANALOG_MAX;
            analog_count = 3'h5 - drop[2:0];
        end
    endfunction : analog_count

    // Spreads a per-channel mask onto pin positions
    function automatic logic [port_six_pkg::PIN_W-1:0] chan_to_pins(
        input logic [port_six_pkg::CHAN_W-1:0] chan
    );
        logic [port_six_pkg::PIN_W-1:0] pins;
        pins = '0;
        for (int k = 0; k < port_six_pkg::CHAN_W; k++) begin
            pins[port_six_pkg::CHAN_PIN[k]] = chan[k];
        end
        chan_to_pins = pins;
    endfunction : chan_to_pins

    // Places a pin-wide value in the low bits of a data byte
    function automatic logic [port_six_pkg::DATA_W-1:0] widen(
        input logic [port_six_pkg::PIN_W-1:0] value
    );
        widen = {2'b00, value};
    endfunction : widen

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [5:0] output_latch_reg;
    logic [5:0] output_latch_next;
    logic [5:0] pin_direction_reg;
    logic [5:0] pin_direction_next;
    logic [7:0] converter_pin_config_reg;
    logic [7:0] converter_pin_config_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [5:0] pin_out_reg;
    logic [5:0] pin_oe_reg;
    logic timer_clock_reg;
    logic [4:0] chan_en_reg;
    logic neg_ref_reg;
    logic pos_ref_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    wire sel_data = (reg_addr == port_six_pkg::PIN_LEVEL_DATA_OFS);
    wire sel_latch = (reg_addr == port_six_pkg::OUTPUT_LATCH_OFS);
    wire sel_dir = (reg_addr == port_six_pkg::PIN_DIRECTION_OFS);
    wire sel_config = (reg_addr == port_six_pkg::CONVERTER_PIN_CONFIG_OFS);

    // A write to the data register and one to the latch register land in
    // the same latch, so software may use either for the same effect
    wire latch_write = reg_wr && (sel_data || sel_latch);
    wire dir_write = reg_wr && sel_dir;
    wire config_write = reg_wr && sel_config;

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling

    pin_sample_if pin_link();

    assign pin_link.raw = pin_in;

    pin_sampler u_sampler (
        .clk(clk),
        .reset_n(reset_n),
        .pins(pin_link)
    );

    wire [5:0] pin_level = pin_link.level;

    ////////////////////////////////////////////////////////////////////////////
    // Analog selection

    wire [3:0] analog_field =
        converter_pin_config_reg[port_six_pkg::ANALOG_SELECT_LSB +: port_six_pkg::FIELD_W];
    wire neg_ref_sel = converter_pin_config_reg[port_six_pkg::NEG_REFERENCE_SELECT_BIT];
    wire pos_ref_sel = converter_pin_config_reg[port_six_pkg::POS_REFERENCE_SELECT_BIT];
    wire [2:0] chan_count = analog_count(analog_field);

    logic [4:0] chan_mask;

    always_comb begin
        chan_mask = '0;
        for (int k = 0; k < port_six_pkg::CHAN_W; k++) begin
            chan_mask[k] = (3'(k) < chan_count);
        end
    end

    // A pin chosen as a reference input is analog even with its channel off
    logic [5:0] ref_pins;

    always_comb begin
        ref_pins = '0;
        ref_pins[port_six_pkg::NEG_REF_PIN_BIT] = neg_ref_sel;
        ref_pins[port_six_pkg::POS_REF_PIN_BIT] = pos_ref_sel;
    end

    // Pin 4 has no channel and so is never analog
    wire [5:0] analog_pins = chan_to_pins(chan_mask) | ref_pins;

    // Comparator reference output claims bit 2 for both directions
    logic [5:0] cmp_ref_pins;

    always_comb begin
        cmp_ref_pins = '0;
        cmp_ref_pins[port_six_pkg::CMP_REF_PIN_BIT] = cmp_ref_out_en;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Digital input path

    // Analog pins read as zero so a floating analog level never toggles
    // the digital buffer into a read that software might trust
    wire [5:0] digital_in_en = ~analog_pins & ~cmp_ref_pins;
    wire [5:0] data_read = pin_level & digital_in_en;

    ////////////////////////////////////////////////////////////////////////////
    // Output drive

    // Direction decides the driver on every pin, analog or not, save bit 2 while the
    // comparator reference output is on; software must keep analog pins at one
    // or the latch fights the analog source
    wire [5:0] drive_en = ~pin_direction_reg & ~cmp_ref_pins;

    ////////////////////////////////////////////////////////////////////////////
    // Register next values

    assign output_latch_next = latch_write ? reg_wdata[5:0] : output_latch_reg;
    assign pin_direction_next = dir_write ? reg_wdata[5:0] : pin_direction_reg;
    assign converter_pin_config_next = config_write ?
        (reg_wdata & port_six_pkg::CONFIG_WRITE_MASK) : converter_pin_config_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Read mux

    wire [7:0] read_data = widen(data_read);
    wire [7:0] read_latch = widen(output_latch_reg);
    wire [7:0] read_dir = widen(pin_direction_reg);
    wire [7:0] read_config = converter_pin_config_reg;

    logic [7:0] read_mux;

    always_comb begin
        if (sel_data) begin
            read_mux = read_data;
        end else if (sel_latch) begin
            read_mux = read_latch;
        end else if (sel_dir) begin
            read_mux = read_dir;
        end else if (sel_config) begin
            read_mux = read_config;
        end else begin
            read_mux = 8'h00;
        end
    end

    // Read data stand only in the cycle after the strobe, zero otherwise
    assign rdata_next = reg_rd ? read_mux : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Software-visible registers

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            output_latch_reg <= port_six_pkg::OUTPUT_LATCH_RST;
            pin_direction_reg <= port_six_pkg::PIN_DIRECTION_RST;
            converter_pin_config_reg <= port_six_pkg::CONVERTER_PIN_CONFIG_RST;
        end else begin
            output_latch_reg <= output_latch_next;
            pin_direction_reg <= pin_direction_next;
            converter_pin_config_reg <= converter_pin_config_next;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pad outputs

    // Registered so the pads see no decode glitches; costs one cycle after
    // a write before the pin moves
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_out_reg <= 6'h00;
            pin_oe_reg <= 6'h00;
        end else begin
            pin_out_reg <= output_latch_reg & drive_en;
            pin_oe_reg <= drive_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timer clock and converter outputs

    // Taken from the filtered level whatever the direction bit, so a
    // driven pin clocks the timer from its own output
    wire timer_clock_next = timer_clk_sel & pin_level[port_six_pkg::TIMER_PIN_BIT];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_clock_reg <= 1'b0;
            chan_en_reg <= 5'h00;
            neg_ref_reg <= 1'b0;
            pos_ref_reg <= 1'b0;
        end else begin
            timer_clock_reg <= timer_clock_next;
            chan_en_reg <= chan_mask;
            neg_ref_reg <= neg_ref_sel;
            pos_ref_reg <= pos_ref_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output ports

    assign reg_rdata = rdata_reg;
    assign pin_out = pin_out_reg;
    assign pin_oe = pin_oe_reg;
    assign timer_ext_clock_in = timer_clock_reg;
    assign converter_chan_en = chan_en_reg;
    assign neg_reference_pin = neg_ref_reg;
    assign pos_reference_pin = pos_ref_reg;

endmodule : port_six_gpio

// ---- verification/port_six_gpio_props.sv ----
// Concurrent checks on the pins and register port of the six-bit port.
// Assumes it is bound to port_six_gpio and sees only its top-level ports.
`timescale 1ns/1ps
module port_six_gpio_props (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    input wire logic cmp_ref_out_en,
    input wire logic timer_clk_sel,
    input wire logic timer_ext_clock_in,
    input wire logic [4:0] converter_chan_en
);
    logic [7:0] wdata_d1_reg;
    logic [7:0] wdata_d2_reg;
    wire logic latch_wr = reg_wr && (reg_addr == 4'h0 || reg_addr == 4'h1);

    ////////////////////////////////////////////////////////////////////////////
    // Write data delayed to line up with the two-edge register-to-pin path
    always_ff @(posedge clk) begin
        wdata_d1_reg <= reg_wdata;
        wdata_d2_reg <= wdata_d1_reg;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    AST_HIGH_BITS_ZERO: assert property (reg_rdata[7:6] == 2'h0)
        else $error("read data bits 7:6 not zero");
    AST_UNMAPPED_ZERO: assert property (reg_rd && reg_addr > 4'h3 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_LATCH_READBACK: assert property (latch_wr ##1 (reg_rd && reg_addr == 4'h1)
        |=> reg_rdata == {2'h0, wdata_d2_reg[5:0]})
        else $error("latch read back differs from written value");
    AST_DIR_TO_OE: assert property (reg_wr && reg_addr == 4'h2
        |-> ##2 (pin_oe & 6'h3B) == (~wdata_d2_reg[5:0] & 6'h3B))
        else $error("output enable does not follow direction write");
    AST_OUT_DRIVEN_ONLY: assert property ((pin_out & ~pin_oe) == 6'h00)
        else $error("pin value driven while output disabled");
    AST_CMP_REF_OFF: assert property ($past(cmp_ref_out_en) |-> !pin_oe[2])
        else $error("bit 2 driven while reference output enabled");
    AST_TIMER_SEL: assert property (timer_ext_clock_in |-> $past(timer_clk_sel))
        else $error("timer clock active while not selected");
    AST_RESET_ANALOG: assert property ($rose(reset_n) |=> converter_chan_en == 5'h1F)
        else $error("channels not all analog after reset");
    AST_ANALOG_READ_ZERO: assert property (reg_rd && reg_addr == 4'h0 && !$past(reg_wr)
        |=> (reg_rdata[5:0] & {converter_chan_en[4], 1'b0, converter_chan_en[3:0]}) == 6'h00)
        else $error("analog pin read as nonzero");

    COV_LATCH_READBACK: cover property (latch_wr ##1 (reg_rd && reg_addr == 4'h1));
    COV_TIMER_CLOCK: cover property (timer_ext_clock_in);
    COV_UNMAPPED: cover property (reg_rd && reg_addr > 4'h3);
endmodule : port_six_gpio_props

bind port_six_gpio port_six_gpio_props port_six_gpio_props_inst (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_oe(pin_oe),
    .cmp_ref_out_en(cmp_ref_out_en), .timer_clk_sel(timer_clk_sel),
    .timer_ext_clock_in(timer_ext_clock_in), .converter_chan_en(converter_chan_en)
);

// ---- verification/pin_model.sv ----
// Board-side model of the six port pins.
// Assumes the device wins where both sides drive; an undriven pin floats.
`timescale 1ns/1ps
module pin_model (
    input wire logic clk,
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    input wire logic [5:0] ext_val,
    input wire logic [5:0] ext_en,
    output logic [5:0] pin_in
);
    // No pull resistors, so a floating pin wanders instead of holding a level
    logic [5:0] float_reg = 6'h15;

    always_ff @(posedge clk) begin
        float_reg <= ~float_reg;
    end

    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & float_reg);
endmodule : pin_model

// ---- verification/tb_top.sv ----
// Self-checking bench for the six-bit port: register port, pins, analog share.
// Assumes the pin model on the far side and the bound property checker.
`timescale 1ns/1ps
module tb_top;
    logic clk, reset_n, reg_wr, reg_rd, cmp_ref_out_en, timer_clk_sel;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, cfg, v;
    logic [5:0] pin_in, pin_out, pin_oe, ext_val, ext_en, lat, dir, lvl, known, cm, an;
    logic timer_ext_clock_in, neg_reference_pin, pos_reference_pin;
    logic [4:0] converter_chan_en;
    integer seed = 68;
    int n_fail = 0;
    int checked = 0;

    port_six_gpio port_six_gpio_inst (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .cmp_ref_out_en(cmp_ref_out_en), .timer_clk_sel(timer_clk_sel),
        .timer_ext_clock_in(timer_ext_clock_in), .converter_chan_en(converter_chan_en),
        .neg_reference_pin(neg_reference_pin), .pos_reference_pin(pos_reference_pin));
    pin_model pin_model_inst (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("TB: %0d comparisons, %0d mismatches", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
        checked++;
        if ((got & mask) !== (exp & mask)) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h mask %h", $time, got, exp, mask);
        end
    endtask : check

    // Strobe is left high so writes can run back to back; next task drops it
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] mask);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(reg_rdata, exp, mask);
        @(posedge clk);
    endtask : rd

    // Bit 4 of the result is always zero, so channel 4 lands on pin 5 when
    // the pin-wide mask is shifted down past it for the channel compare
    function automatic logic [5:0] analog_pins(input logic [7:0] c);
        int cnt;
        logic [5:0] m;
        cnt = (c[3:0] <= 4'hA) ? 5 : 15 - c[3:0];
        m = {cnt > 4, 1'b0, cnt > 3, cnt > 2, cnt > 1, cnt > 0};
        m[3] = m[3] | c[4];
        m[2] = m[2] | c[5];
        return m;
    endfunction : analog_pins

    // Covers the 3-stage filter plus the register and output stages
    task automatic settle_and_check;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        cm = cmp_ref_out_en ? 6'h04 : 6'h00;
        an = analog_pins(cfg);
        an = {an[5], an[5], an[3:0]};
        lvl = (~dir & ~cm & lat) | ((dir | cm) & ext_val);
        known = (~dir & ~cm) | ext_en;
        check({2'h0, pin_oe}, {2'h0, ~dir & ~cm}, 8'hFF);
        check({2'h0, pin_out}, {2'h0, lat & ~dir & ~cm}, 8'hFF);
        check({7'h0, timer_ext_clock_in}, {7'h0, timer_clk_sel & lvl[4]}, {7'h0, known[4]});
        check({6'h0, neg_reference_pin, pos_reference_pin}, {6'h0, cfg[5:4]}, 8'hFF);
        check({3'h0, converter_chan_en}, {2'h0, an}, {3'h0, 1'b1, ~cfg[4], ~cfg[5], 2'h3});
        @(posedge clk);
        an = analog_pins(cfg);
        rd(4'h0, {2'h0, lvl & ~an & ~cm}, {2'h3, known | an | cm});
        rd(4'h1, {2'h0, lat}, 8'hFF);
        rd(4'h2, {2'h0, dir}, 8'hFF);
        rd(4'h3, cfg, 8'hFF);
    endtask : settle_and_check

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        $display("ERROR %0t: run did not finish in time", $time);
        end_of_test();
    end

    initial begin
        reset_n = 1'b0;
        {reg_wr, reg_rd, cmp_ref_out_en, timer_clk_sel} = 4'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        ext_val = 6'h3F;
        ext_en = 6'h3F;
        lat = 6'h00;
        dir = 6'h3F;
        cfg = 8'h00;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        settle_and_check();
        for (int a = 4; a < 16; a++) begin
            wr(a[3:0], 8'hFF);
            rd(a[3:0], 8'h00, 8'hFF);
        end
        settle_and_check();
        for (int i = 0; i < 40; i++) begin
            v = $random(seed);
            cmp_ref_out_en <= v[0] & v[7];
            timer_clk_sel <= v[1];
            ext_val <= $random(seed);
            ext_en <= $random(seed);
            v = $random(seed);
            lat = v[5:0];
            wr(v[6] ? 4'h0 : 4'h1, v);
            rd(4'h1, {2'h0, lat}, 8'hFF);
            v = $random(seed);
            dir = v[5:0];
            wr(4'h2, v);
            v = $random(seed);
            cfg = {2'h0, v[5:4], i[3:0]};
            wr(4'h3, {v[7:4], i[3:0]});
            settle_and_check();
        end
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        lat = 6'h00;
        dir = 6'h3F;
        cfg = 8'h00;
        @(posedge clk);
        settle_and_check();
        end_of_test();
    end
endmodule : tb_top
